// >>> logic/gpx_port.sv
`timescale 1ns/100ps

// Functional notes
// - interrupt input pin events raise vector request
// - input pins with option set and no peripheral drive can request, vector sensitivity applies
// - enabled interrupt pin levels are ANDed
// - pending latch hidden, cleared by vector fetch
// - changing sensitivity discards the pending request
// - direction one drives latch, reads latch
// - option selects push-pull or open-drain drive
// - driving alternate function overrides direction, option, data
// - peripheral drive forces output, its drive type
// - peripheral input pins stay input, readable
// - input pin with alt output reads alt
// - output pin feeds latch to alt input
// - standard pin mode decode from direction, option
// - true open-drain pins: no pull-up, no push-pull
// - low-power modes keep port, pin irq wakes
// - irq only if configured and cpu unmasked
// - data latch resets zero, always writable
// - data read: latch for outputs, alt output for alt-driven inputs, pin otherwise
// - bit n of data, direction, option registers is pin n
// - direction zero is input, writes only latch
// - sensitivity codes: fall+low, rise, fall, both
module gpx_port
   import gpx_pkg::*;
#(
   parameter int unsigned         NPIN    = GPX_NPIN,
   parameter logic [NPIN-1:0]     TRUE_OD = '0
) (
   input  wire logic              MCLK,
   input  wire logic              RST,
   input  wire logic              CE,
   input  wire logic              HSEL,
   input  wire logic [31:0]       HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output logic      [31:0]       HRDATA,
   output logic                   HREADYOUT,
   output logic                   HRESP,
   input  wire logic [NPIN-1:0]   PIN_IN,
   output logic      [NPIN-1:0]   PIN_OUT,
   output logic      [NPIN-1:0]   PIN_OE,
   output logic      [NPIN-1:0]   PIN_PULLUP,
   input  wire logic [NPIN-1:0]   ALT_EN,
   input  wire logic [NPIN-1:0]   ALT_DRIVE,
   input  wire logic [NPIN-1:0]   ALT_OUT,
   input  wire logic [NPIN-1:0]   ALT_OD,
   output logic      [NPIN-1:0]   ALT_IN,
   input  wire logic              CPU_IMASK,
   input  wire logic              VEC_FETCH,
   output logic                   IRQ_REQ
);

   // word of register data, narrow value in the low bits
   function automatic logic [31:0] gpx_word(input logic [NPIN-1:0] v);
      gpx_word = '0;
      gpx_word[NPIN-1:0] = v;
   endfunction : gpx_word

   // pins that take part in the vector as interrupt inputs
   function automatic logic [NPIN-1:0] gpx_irq_pins(
      input logic [NPIN-1:0] dir,
      input logic [NPIN-1:0] opt,
      input logic [NPIN-1:0] adrv
   );
      gpx_irq_pins = ~dir & opt & ~adrv;
   endfunction : gpx_irq_pins

   // bus side: phase tracker, captured address and read data
   gpx_bus_t              bus_st_q;
   gpx_bus_t              bus_st_d;
   logic [GPX_AW-1:0]     addr_q;
   logic [GPX_AW-1:0]     addr_d;
   logic                  word_q;
   logic                  word_d;
   logic [31:0]           rdata_q;
   logic [31:0]           rdata_d;
   logic                  rdy_q;
   logic                  resp_q;
   logic                  addr_ph;

   // software visible port registers and write strobes
   logic [NPIN-1:0]       data_q;
   logic [NPIN-1:0]       data_d;
   logic [NPIN-1:0]       dir_q;
   logic [NPIN-1:0]       dir_d;
   logic [NPIN-1:0]       opt_q;
   logic [NPIN-1:0]       opt_d;
   logic [1:0]            sens_q;
   logic [1:0]            sens_d;
   logic                  sens_chg;
   logic                  wr_en;

   // two-stage synchroniser on the pin levels
   logic [NPIN-1:0]       pin_s1_q;
   logic [NPIN-1:0]       pin_s2_q;

   // pin drive decode and registered pin outputs
   logic [NPIN-1:0]       adrv;
   logic [NPIN-1:0]       drv_val;
   logic [NPIN-1:0]       drv_od;
   logic [NPIN-1:0]       drv_on;
   logic [NPIN-1:0]       out_d;
   logic [NPIN-1:0]       oe_d;
   logic [NPIN-1:0]       pu_d;
   logic [NPIN-1:0]       alt_in_d;
   logic [NPIN-1:0]       rd_pins;
   logic [NPIN-1:0]       out_q;
   logic [NPIN-1:0]       oe_q;
   logic [NPIN-1:0]       pu_q;
   logic [NPIN-1:0]       alt_in_q;

   // vector line, trigger and pending request
   logic [NPIN-1:0]       irq_pins;
   logic                  line;
   logic                  line_q;
   logic                  trig;
   logic                  clr;
   logic                  pend_q;
   logic                  pend_d;
   logic                  irq_q;
   logic                  irq_d;

   // alternate function that drives the pin
   assign adrv = ALT_EN & ALT_DRIVE;

   // ahb address phase accepted this cycle
   assign addr_ph = HSEL & HTRANS[GPX_HTRANS_ACT] & HREADY;

   // data register read value per pin
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         if (adrv[i] && !dir_q[i]) begin
            rd_pins[i] = ALT_OUT[i];
         end else if (dir_q[i]) begin
            rd_pins[i] = data_d[i];
         end else begin
            rd_pins[i] = pin_s2_q[i];
         end
      end
   end

   // bus phase tracking and read data
   always_comb begin
      bus_st_d = GPX_BUS_IDLE;
      addr_d   = addr_q;
      word_d   = word_q;
      rdata_d  = rdata_q;
      if (addr_ph) begin
         addr_d   = HADDR[GPX_AW-1:0];
         word_d   = (HSIZE == GPX_HSIZE_WORD);
         bus_st_d = HWRITE ? GPX_BUS_WR : GPX_BUS_RD;
         if (!HWRITE) begin
            case (HADDR[GPX_AW-1:0])
               GPX_OFS_DATA: rdata_d = gpx_word(rd_pins);
               GPX_OFS_DIR:  rdata_d = gpx_word(dir_d);
               GPX_OFS_OPT:  rdata_d = gpx_word(opt_d);
               GPX_OFS_SENS: begin
                  rdata_d = '0;
                  rdata_d[GPX_SENS_LSB +: GPX_SENS_W] = sens_d;
               end
               default:      rdata_d = '0;
            endcase
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         bus_st_q <= GPX_BUS_IDLE;
         addr_q   <= '0;
         word_q   <= 1'b0;
         rdata_q  <= GPX_RST_RDATA;
         rdy_q    <= 1'b1;
         resp_q   <= GPX_HRESP_OKAY;
      end else if (CE) begin
         bus_st_q <= bus_st_d;
         addr_q   <= addr_d;
         word_q   <= word_d;
         rdata_q  <= rdata_d;
         rdy_q    <= 1'b1; // zero wait states
         resp_q   <= GPX_HRESP_OKAY; // every access answers okay
      end
   end

   // register writes in the data phase
   assign wr_en = (bus_st_q == GPX_BUS_WR) && word_q;

   always_comb begin
      data_d   = data_q;
      dir_d    = dir_q;
      opt_d    = opt_q;
      sens_d   = sens_q;
      sens_chg = 1'b0;
      if (wr_en) begin
         case (addr_q)
            GPX_OFS_DATA: data_d = HWDATA[NPIN-1:0];
            GPX_OFS_DIR:  dir_d  = HWDATA[NPIN-1:0];
            GPX_OFS_OPT:  opt_d  = HWDATA[NPIN-1:0];
            GPX_OFS_SENS: begin
               sens_d   = HWDATA[GPX_SENS_LSB +: GPX_SENS_W];
               sens_chg = (sens_d != sens_q);
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         data_q <= GPX_RST_DATA;
         dir_q  <= GPX_RST_DIR;
         opt_q  <= GPX_RST_OPT;
         sens_q <= GPX_RST_SENS;
      end else if (CE) begin
         data_q <= data_d;
         dir_q  <= dir_d;
         opt_q  <= opt_d;
         sens_q <= sens_d;
      end
   end

   // pin synchroniser
   always_ff @(posedge MCLK) begin
      if (RST) begin
         pin_s1_q <= '1;
         pin_s2_q <= '1;
      end else if (CE) begin
         pin_s1_q <= PIN_IN;
         pin_s2_q <= pin_s1_q;
      end
   end

   // pin drive decode
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         if (adrv[i]) begin
            drv_on[i]  = 1'b1;
            drv_val[i] = ALT_OUT[i];
            drv_od[i]  = ALT_OD[i] | TRUE_OD[i];
         end else begin
            drv_on[i]  = dir_q[i];
            drv_val[i] = data_q[i];
            drv_od[i]  = ~opt_q[i] | TRUE_OD[i];
         end
         // push-pull drives both levels, open-drain only low
         if (!drv_on[i]) begin
            out_d[i] = 1'b0;
            oe_d[i]  = 1'b0;
         end else if (drv_od[i]) begin
            out_d[i] = 1'b0;
            oe_d[i]  = ~drv_val[i];
         end else begin
            out_d[i] = drv_val[i];
            oe_d[i]  = 1'b1;
         end
         // pull-up only on standard pins in input mode
         pu_d[i] = ~drv_on[i] & opt_q[i] & ~TRUE_OD[i];
         // peripheral input sees latch when pin is an output
         if (dir_q[i] && !adrv[i]) begin
            alt_in_d[i] = data_q[i];
         end else begin
            alt_in_d[i] = pin_s2_q[i];
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         out_q    <= '0;
         oe_q     <= '0;
         pu_q     <= '0;
         alt_in_q <= '0;
      end else if (CE) begin
         out_q    <= out_d;
         oe_q     <= oe_d;
         pu_q     <= pu_d;
         alt_in_q <= alt_in_d;
      end
   end

   // combined vector line and trigger
   assign irq_pins = gpx_irq_pins(dir_q, opt_q, adrv);
   assign line     = &(pin_s2_q | ~irq_pins);
   assign clr      = VEC_FETCH | sens_chg;

   always_comb begin
      case (sens_q)
         GPX_SENS_FLOW: trig = ~line;
         GPX_SENS_RISE: trig = ~line_q & line;
         GPX_SENS_FALL: trig = line_q & ~line;
         GPX_SENS_BOTH: trig = line_q ^ line;
         default:       trig = 1'b0;
      endcase
      // a new event wins over a clear in the same cycle
      pend_d = trig | (pend_q & ~clr);
      irq_d  = pend_d & ~CPU_IMASK;
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         line_q <= 1'b1;
         pend_q <= 1'b0;
         irq_q  <= 1'b0;
      end else if (CE) begin
         line_q <= line;
         pend_q <= pend_d;
         irq_q  <= irq_d;
      end
   end

   // outputs straight from flops
   assign HRDATA     = rdata_q;
   assign HREADYOUT  = rdy_q;
   assign HRESP      = resp_q;
   assign PIN_OUT    = out_q;
   assign PIN_OE     = oe_q;
   assign PIN_PULLUP = pu_q;
   assign ALT_IN     = alt_in_q;
   assign IRQ_REQ    = irq_q;

endmodule : gpx_port

// >>> logic/gpx_pkg.sv
package gpx_pkg;

   // port width and register map (byte addresses, one word each)
   localparam int unsigned GPX_NPIN      = 8;
   localparam int unsigned GPX_AW        = 8;
   localparam logic [7:0]  GPX_OFS_DATA  = 8'h00;
   localparam logic [7:0]  GPX_OFS_DIR   = 8'h04;
   localparam logic [7:0]  GPX_OFS_OPT   = 8'h08;
   localparam logic [7:0]  GPX_OFS_SENS  = 8'h0c;

   // reset values
   localparam logic [7:0]  GPX_RST_DATA  = 8'h00;
   localparam logic [7:0]  GPX_RST_DIR   = 8'h00;
   localparam logic [7:0]  GPX_RST_OPT   = 8'h00;
   localparam logic [1:0]  GPX_RST_SENS  = 2'h0;
   localparam logic [31:0] GPX_RST_RDATA = 32'h0000_0000;

   // sensitivity field position and codes
   localparam int unsigned GPX_SENS_LSB  = 0;
   localparam int unsigned GPX_SENS_W    = 2;
   localparam logic [1:0]  GPX_SENS_FLOW = 2'h0;
   localparam logic [1:0]  GPX_SENS_RISE = 2'h1;
   localparam logic [1:0]  GPX_SENS_FALL = 2'h2;
   localparam logic [1:0]  GPX_SENS_BOTH = 2'h3;

   // ahb-lite codes
   localparam int unsigned GPX_HTRANS_ACT = 1;
   localparam logic [2:0]  GPX_HSIZE_WORD = 3'h2;
   localparam logic        GPX_HRESP_OKAY = 1'b0;

   // bus phase tracker
   typedef enum logic [2:0] {
      GPX_BUS_IDLE = 3'b001,
      GPX_BUS_WR   = 3'b010,
      GPX_BUS_RD   = 3'b100
   } gpx_bus_t;

endpackage : gpx_pkg

// >>> tb/gpx_port_monitor.sv
`timescale 1ns/100ps
// port-side checks on pin drive, peripheral override and request latch
module gpx_port_monitor #(
   parameter logic [7:0] TRUE_OD = '0
) (
   input wire logic       MCLK,
   input wire logic       RST,
   input wire logic       HSEL,
   input wire logic [7:0] PIN_OUT,
   input wire logic [7:0] PIN_OE,
   input wire logic [7:0] PIN_PULLUP,
   input wire logic [7:0] ALT_EN,
   input wire logic [7:0] ALT_DRIVE,
   input wire logic [7:0] ALT_OUT,
   input wire logic [7:0] ALT_OD,
   input wire logic [7:0] ALT_IN,
   input wire logic       CPU_IMASK,
   input wire logic       VEC_FETCH,
   input wire logic       IRQ_REQ
);
   logic [7:0] pp_d, od_d, pp_q, od_q, ao_q;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   // peripheral drive kinds, delayed to line up with the pin flops
   always_comb begin
      pp_d = ALT_EN & ALT_DRIVE & ~ALT_OD & ~TRUE_OD;
      od_d = ALT_EN & ALT_DRIVE & (ALT_OD | TRUE_OD);
   end
   always_ff @(posedge MCLK) begin
      pp_q <= pp_d;
      od_q <= od_d;
      ao_q <= ALT_OUT;
   end
   a_irq_masked: assert property (CPU_IMASK |=> !IRQ_REQ)
      else $error("request raised while masked");
   a_irq_held:
      assert property (IRQ_REQ && !CPU_IMASK && !VEC_FETCH && !$past(HSEL)
         |=> IRQ_REQ) else $error("pending request lost");
   a_pp_out: assert property ((PIN_OUT & ~PIN_OE) == '0)
      else $error("high level without drive enable");
   a_pull_input:
      assert property ((PIN_PULLUP & (PIN_OE | TRUE_OD)) == '0)
      else $error("pull-up on a driven or true open-drain pin");
   a_true_od: assert property ((PIN_OUT & TRUE_OD) == '0)
      else $error("true open-drain pin driven high");
   a_alt_pp:
      assert property ((pp_q & (~PIN_OE | (PIN_OUT ^ ao_q))) == '0)
      else $error("peripheral push-pull drive not on pin");
   a_alt_od:
      assert property ((od_q & (PIN_OUT | ~(PIN_OE ^ ao_q))) == '0)
      else $error("peripheral open-drain drive not on pin");
   a_alt_in:
      assert property ((PIN_OE & ~(pp_q | od_q) & (ALT_IN ^ PIN_OUT)) == '0)
      else $error("peripheral input differs from latch");
endmodule : gpx_port_monitor

bind gpx_port gpx_port_monitor #(.TRUE_OD(TRUE_OD)) i_gpx_port_monitor (
   .MCLK, .RST, .HSEL, .PIN_OUT, .PIN_OE, .PIN_PULLUP, .ALT_EN, .ALT_DRIVE,
   .ALT_OUT, .ALT_OD, .ALT_IN, .CPU_IMASK, .VEC_FETCH, .IRQ_REQ);

// >>> tb/gpx_board.sv
`timescale 1ns/100ps
// board around the pins: our drive, else external source, else pull-up
module gpx_board (
   input  wire logic       clk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pin_pullup,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] level
);
   logic [7:0] tog_q = 8'h5a;
   // a line nobody holds wanders every cycle
   always_ff @(posedge clk) tog_q <= ~tog_q;
   always_comb level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                     | (~pin_oe & ~ext_en & (pin_pullup | tog_q));
endmodule : gpx_board

// >>> tb/gpx_port_test.sv
`timescale 1ns/100ps
module gpx_port_test
   import gpx_pkg::*;
;
   localparam logic [7:0] TOD = 8'h80;
   logic        MCLK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
   logic        CPU_IMASK = 1'b1, VEC_FETCH = 1'b0, IRQ_REQ, HREADYOUT, HRESP;
   logic [1:0]  HTRANS = 2'h0;
   logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, r;
   logic [7:0]  ALT_EN = '0, ALT_DRIVE = '0, ALT_OUT = '0, ALT_OD = '0;
   logic [7:0]  ext_en = 8'hff, ext_val = 8'h00, lvl;
   logic [7:0]  PIN_OUT, PIN_OE, PIN_PULLUP, ALT_IN;
   int          bad_count = 0, cmp_count = 0;

   gpx_port #(.TRUE_OD(TOD)) i_gpx_port (.MCLK, .RST, .CE(1'b1), .HSEL,
      .HADDR, .HTRANS, .HWRITE, .HSIZE(GPX_HSIZE_WORD), .HWDATA,
      .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .PIN_IN(lvl),
      .PIN_OUT, .PIN_OE, .PIN_PULLUP, .ALT_EN, .ALT_DRIVE, .ALT_OUT,
      .ALT_OD, .ALT_IN, .CPU_IMASK, .VEC_FETCH, .IRQ_REQ);
   gpx_board i_gpx_board (.clk(MCLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE),
      .pin_pullup(PIN_PULLUP), .ext_en, .ext_val, .level(lvl));

   always #5 MCLK = ~MCLK;

   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   task automatic chk(input string n, input logic [39:0] e, g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one bus phase, held until hready is seen high
   task automatic wt;
      int n;
      n = 0;
      @(posedge MCLK);
      while (HREADYOUT !== 1'b1) begin
         n++;
         if (n > 50) begin
            bad_count++;
            results();
         end
         @(posedge MCLK);
      end
   endtask : wt

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR  <= {24'h0, a};
      wt();
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      wt();
      r = HRDATA;
   endtask : bus

   task automatic ev(input logic [7:0] v, input logic e);
      ext_val <= v;
      repeat (8) @(posedge MCLK);
      chk("irq", e, IRQ_REQ);
   endtask : ev

   task automatic ft;
      VEC_FETCH <= 1'b1;
      @(posedge MCLK);
      VEC_FETCH <= 1'b0;
   endtask : ft

   // expected {read, out, oe, pullup, alt input} of one configuration
   function automatic logic [39:0] f_exp(input logic [7:0] d, di, op, ae,
                                         ad, ao, aod, een, ev);
      logic [7:0] drv, od, v, oe, out, pu, lv;
      drv = ae & ad;
      od  = (drv & (aod | TOD)) | (~drv & (~op | TOD));
      v   = (drv & ao) | (~drv & d);
      oe  = (drv | di) & (~od | ~v);
      out = (drv | di) & ~od & v;
      pu  = ~(drv | di) & op & ~TOD;
      lv  = (oe & out) | (~oe & een & ev) | (~oe & ~een & pu);
      return {(drv & ~di & ao) | (di & d) | (~di & ~drv & lv), out, oe, pu,
              (di & ~drv & d) | ~(di & ~drv) & lv};
   endfunction : f_exp

   initial begin
      logic [7:0]  d, di, op, ae, ad, ao, aod, een, ev0;
      logic [39:0] e;
      logic [1:0]  c;
      e = $urandom(32'hb53e5df4);
      repeat (16) @(posedge MCLK);
      RST <= 1'b0;
      chk("pins", '0, {PIN_OUT, PIN_OE, PIN_PULLUP, ALT_IN});
      bus(1'b1, 8'h10, 32'hffff_ffff);
      for (int a = 0; a < 20; a += 4) begin
         bus(1'b0, a[7:0], '0);
         chk("reg", '0, r);
      end
      $display("reset test done");
      for (int i = 0; i < 24; i++) begin
         d = $urandom; di = $urandom; op = $urandom;
         ae = $urandom & ~(op & ~di);
         ad = $urandom; ao = $urandom; aod = $urandom; ev0 = $urandom;
         een = $urandom | ~(op & ~di & ~TOD);
         bus(1'b1, GPX_OFS_DATA, {24'h0, d});
         bus(1'b1, GPX_OFS_DIR, {24'h0, di});
         bus(1'b1, GPX_OFS_OPT, {24'h0, op});
         ALT_EN <= ae; ALT_DRIVE <= ad; ALT_OUT <= ao; ALT_OD <= aod;
         ext_en <= een; ext_val <= ev0;
         repeat (6) @(posedge MCLK);
         e = f_exp(d, di, op, ae, ad, ao, aod, een, ev0);
         chk("pins", e[31:0], {PIN_OUT, PIN_OE, PIN_PULLUP, ALT_IN});
         bus(1'b0, GPX_OFS_DATA, '0);
         chk("data", e[39:32], r);
      end
      $display("pin test done");
      ALT_EN <= '0;
      ext_en <= 8'hff;
      ext_val <= 8'hff;
      bus(1'b1, GPX_OFS_DIR, '0);
      bus(1'b1, GPX_OFS_OPT, 32'h3);
      CPU_IMASK <= 1'b0;
      ft();
      for (int i = 1; i < 5; i++) begin
         c = i[1:0];
         bus(1'b1, GPX_OFS_SENS, {30'h0, c});
         ev(8'hff, 1'b0);
         ev(8'hfd, c != 1);
         ft();
         ev(8'hfd, c == 0);
         ev(8'hff, c != 2);
         ft();
         ev(8'hfe, c != 1);
         ft();
         ev(8'hfc, c == 0);
         ev(8'hfd, c == 0);
         CPU_IMASK <= 1'b1;
         ev(8'hfd, 1'b0);
         CPU_IMASK <= 1'b0;
         ev(8'hff, c != 2);
      end
      $display("interrupt test done");
      results();
   end
endmodule : gpx_port_test
